// >>> hw/adcc_control.sv
// Converter control: registers, clocking, triggering, result placement, pin control
//
// Function
// - Mid pin register, bit n is channel 8+n
// - High pin register, bit n is channel 16+n
// - Disabled pin: driver tristated, pull-up off
// - Disabled pin: port read returns zero
// - Converter off in reset or channel all ones
// - Idle between conversions, lowest power
// - 10-bit: 11-bit raw rounded, both result registers
// - 8-bit: 9-bit raw rounded, low register only
// - Stored result sets done flag, optional interrupt
// - Compare enable compares every result
// - Four clock sources, bus clock after reset
// - Halved bus plus divider reaches bus/16
// - Internal async clock runs in wait, stop3
// - Divide selected source by 1,2,4,8
// - Trigger enable: rising edge starts conversion
// - Edge during conversion ignored, not queued
// - Continuous: only the first edge counts
// - Software or hardware start, all options
// - Clock select 00 bus,01 half,10 alt,11 async
// - Divide field 00..11 gives 1,2,4,8
// - Mode 00 8-bit, 10 10-bit
// - Status write, channel not all ones, starts unless trigger enabled
//
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module adcc_control import adcc_pkg::*; #(
  parameter int PIN_COUNT = 16
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  // Clock sources and trigger pins
  input wire logic alternate_clock,
  input wire logic internal_async_clock,
  output logic internal_async_clock_enable,
  input wire logic hw_trigger_input,
  // Analog core
  output logic core_start,
  output logic core_abort,
  output logic core_adck_tick,
  output adcc_core_cfg_t core_cfg,
  input wire logic core_done,
  input wire logic [10:0] core_result,
  // Status
  output logic converter_enable,
  output logic converter_idle,
  output logic done_irq,
  // Shared pins, channels 8 to 23
  input wire logic [PIN_COUNT-1:0] port_out,
  input wire logic [PIN_COUNT-1:0] port_oe,
  input wire logic [PIN_COUNT-1:0] port_pullup,
  input wire logic [PIN_COUNT-1:0] pad_in,
  output logic [PIN_COUNT-1:0] pad_out,
  output logic [PIN_COUNT-1:0] pad_oe,
  output logic [PIN_COUNT-1:0] pad_pullup,
  output logic [PIN_COUNT-1:0] port_read
);

  if (PIN_COUNT != 16) begin : g_bad_pins
    $error("PIN_COUNT must be 16: two 8-bit pin registers");
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [2:0] div_limit(input logic [1:0] sel);
    div_limit = 3'((4'h1 << sel) - 4'h1);
  endfunction

  function automatic logic [9:0] round_raw(input logic [10:0] raw, input logic m10);
    logic [9:0] r;
    r = 10'h000;
    if (m10) begin
      r = (raw[10:1] == 10'h3ff) ? 10'h3ff : raw[10:1] + {9'h000, raw[0]};
    end else begin
      r = (raw[8:1] == 8'hff) ? 10'h0ff : {2'b00, raw[8:1] + {7'h00, raw[0]}};
    end
    round_raw = r;
  endfunction

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  logic [4:0] chan_q;
  logic irq_en_q, cont_q, hw_en_q, cmp_en_q, cmp_gt_q;
  logic [7:0] cfg_q;
  logic [9:0] cv_q, res_q;
  logic [15:0] pin_dis_q;
  logic done_q, lock_q, cont_run_q;
  adcc_state_t state_q;
  logic [7:0] rdata_q;

  logic wr_sc1, wr_mode, rd_hi, rd_lo;
  logic mode10;
  adcc_clk_src_t clk_sel;
  assign wr_sc1 = reg_write && (reg_addr == ADDR_SC1);
  assign wr_mode = reg_write && (reg_addr == ADDR_SC2 || reg_addr == ADDR_CFG ||
                                 reg_addr == ADDR_CV_HI || reg_addr == ADDR_CV_LO);
  assign rd_hi = reg_read && (reg_addr == ADDR_RES_HI);
  assign rd_lo = reg_read && (reg_addr == ADDR_RES_LO);
  assign mode10 = (cfg_q[CFG_MODE_LSB +: 2] == MODE_10BIT);
  assign clk_sel = adcc_clk_src_t'(cfg_q[CFG_CLK_LSB +: 2]);

  always_ff @(posedge clock) begin
    if (reset) begin
      chan_q <= CHANNEL_OFF;
      irq_en_q <= 1'b0;
      cont_q <= 1'b0;
    end else if (wr_sc1) begin
      chan_q <= reg_wdata[4:0];
      irq_en_q <= reg_wdata[SC1_IRQ_EN_BIT];
      cont_q <= reg_wdata[SC1_CONT_BIT];
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      {hw_en_q, cmp_en_q, cmp_gt_q} <= SC2_RESET[SC2_HWTRIG_BIT -: 3];
      cfg_q <= CFG_RESET;
      cv_q <= COMPARE_RESET;
    end else if (reg_write) begin
      if (reg_addr == ADDR_SC2) begin
        {hw_en_q, cmp_en_q, cmp_gt_q} <= reg_wdata[SC2_HWTRIG_BIT -: 3];
      end else if (reg_addr == ADDR_CFG) begin
        cfg_q <= reg_wdata;
      end else if (reg_addr == ADDR_CV_HI) begin
        cv_q[9:8] <= reg_wdata[1:0];
      end else if (reg_addr == ADDR_CV_LO) begin
        cv_q[7:0] <= reg_wdata;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      pin_dis_q <= {PIN_RESET, PIN_RESET};
    end else if (reg_write && reg_addr == ADDR_PIN_MID) begin
      pin_dis_q[7:0] <= reg_wdata;
    end else if (reg_write && reg_addr == ADDR_PIN_HIGH) begin
      pin_dis_q[15:8] <= reg_wdata;
    end
  end

  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset || !reg_read) begin
      rdata_q <= 8'h00;
    end else if (reg_addr == ADDR_SC1) begin
      rdata_q <= {done_q, irq_en_q, cont_q, chan_q};
    end else if (reg_addr == ADDR_SC2) begin
      rdata_q <= {state_q == ST_CONVERT, hw_en_q, cmp_en_q, cmp_gt_q, 4'h0};
    end else if (reg_addr == ADDR_CFG) begin
      rdata_q <= cfg_q;
    end else if (reg_addr == ADDR_RES_HI) begin
      rdata_q <= {6'h00, res_q[9:8]};
    end else if (reg_addr == ADDR_RES_LO) begin
      rdata_q <= res_q[7:0];
    end else if (reg_addr == ADDR_CV_HI) begin
      rdata_q <= {6'h00, cv_q[9:8]};
    end else if (reg_addr == ADDR_CV_LO) begin
      rdata_q <= cv_q[7:0];
    end else if (reg_addr == ADDR_PIN_MID) begin
      rdata_q <= pin_dis_q[7:0];
    end else if (reg_addr == ADDR_PIN_HIGH) begin
      rdata_q <= pin_dis_q[15:8];
    end else begin
      rdata_q <= 8'h00;
    end
  end
  assign reg_rdata = rdata_q;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic trig_s1, trig_s2, trig_s3, alt_s1, alt_s2, alt_s3, asy_s1, asy_s2, asy_s3;
  always_ff @(posedge clock) begin
    if (reset) begin
      {trig_s1, trig_s2, trig_s3} <= 3'h0;
      {alt_s1, alt_s2, alt_s3} <= 3'h0;
      {asy_s1, asy_s2, asy_s3} <= 3'h0;
    end else begin
      {trig_s1, trig_s2, trig_s3} <= {hw_trigger_input, trig_s1, trig_s2};
      {alt_s1, alt_s2, alt_s3} <= {alternate_clock, alt_s1, alt_s2};
      {asy_s1, asy_s2, asy_s3} <= {internal_async_clock, asy_s1, asy_s2};
    end
  end
  logic hw_edge;
  assign hw_edge = trig_s2 && !trig_s3;

  // ---------------------------------------------------------------
  // Conversion clock: source select and divider
  // ---------------------------------------------------------------
  // Divider only runs while converting, so idle burns no toggles
  logic half_q, src_tick, adck_q;
  logic [2:0] div_cnt_q;
  always_comb begin
    case (clk_sel)
      CLK_BUS: src_tick = 1'b1;
      CLK_BUS_HALF: src_tick = half_q;
      CLK_ALT: src_tick = alt_s2 && !alt_s3;
      default: src_tick = asy_s2 && !asy_s3;
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset || state_q != ST_CONVERT) begin
      half_q <= 1'b0;
      div_cnt_q <= 3'h0;
      adck_q <= 1'b0;
    end else begin
      half_q <= !half_q;
      adck_q <= src_tick && (div_cnt_q == div_limit(cfg_q[CFG_DIV_LSB +: 2]));
      if (src_tick) begin
        div_cnt_q <= (div_cnt_q == div_limit(cfg_q[CFG_DIV_LSB +: 2])) ? 3'h0 : div_cnt_q + 3'h1;
      end
    end
  end
  assign core_adck_tick = adck_q;
  // Not gated by any low-power input: the core keeps counting in wait and stop3
  assign internal_async_clock_enable = (clk_sel == CLK_ASYNC) && (state_q == ST_CONVERT);

  // ---------------------------------------------------------------
  // Result handling
  // ---------------------------------------------------------------
  logic [9:0] rounded, diff;
  logic cmp_ge, cond, blocked, xfer, restart;
  assign rounded = round_raw(core_result, mode10);
  assign cmp_ge = mode10 ? (rounded >= cv_q) : (rounded[7:0] >= cv_q[7:0]);
  assign diff = mode10 ? (rounded - cv_q) : {2'b00, rounded[7:0] - cv_q[7:0]};
  assign cond = !cmp_en_q || (cmp_gt_q ? cmp_ge : !cmp_ge);
  assign blocked = mode10 && lock_q;
  assign xfer = core_done && state_q == ST_CONVERT && cond && !blocked && !wr_sc1 && !wr_mode;
  // A blocked result is lost and retried, except a failed single compare
  assign restart = cont_q || (blocked && cond);

  always_ff @(posedge clock) begin
    if (reset) begin
      res_q <= RESULT_RESET;
    end else if (xfer) begin
      res_q <= cmp_en_q ? diff : rounded;
    end
  end

  // Reading the high byte in 10-bit mode holds results until the low byte is read
  always_ff @(posedge clock) begin
    if (reset || rd_lo || !mode10) begin
      lock_q <= 1'b0;
    end else if (rd_hi) begin
      lock_q <= 1'b1;
    end
  end

  // Set wins over the clear by low-byte read; a status write blocks the set and clears
  always_ff @(posedge clock) begin
    if (reset) begin
      done_q <= 1'b0;
    end else if (xfer) begin
      done_q <= 1'b1;
    end else if (wr_sc1 || rd_lo) begin
      done_q <= 1'b0;
    end
  end
  assign done_irq = done_q && irq_en_q;

  // ---------------------------------------------------------------
  // Conversion sequencer
  // ---------------------------------------------------------------
  logic sw_start, hw_start;
  assign sw_start = wr_sc1 && (reg_wdata[4:0] != CHANNEL_OFF) && !hw_en_q;
  assign hw_start = hw_en_q && hw_edge && state_q == ST_IDLE && !cont_run_q;

  always_ff @(posedge clock) begin
    if (reset) begin
      state_q <= ST_DISABLED;
    end else if (wr_sc1) begin
      if (reg_wdata[4:0] == CHANNEL_OFF) begin
        state_q <= ST_DISABLED;
      end else begin
        state_q <= sw_start ? ST_CONVERT : ST_IDLE;
      end
    end else if (wr_mode && state_q == ST_CONVERT) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: state_q <= hw_start ? ST_CONVERT : ST_IDLE;
        ST_CONVERT: state_q <= (core_done && !restart) ? ST_IDLE : ST_CONVERT;
        default: state_q <= ST_DISABLED;
      endcase
    end
  end

  // Hardware-started continuous run swallows later edges until reconfigured
  always_ff @(posedge clock) begin
    if (reset || wr_sc1 || wr_mode) begin
      cont_run_q <= 1'b0;
    end else if (hw_start && cont_q) begin
      cont_run_q <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      core_start <= 1'b0;
      core_abort <= 1'b0;
    end else begin
      core_start <= sw_start || hw_start ||
                    (state_q == ST_CONVERT && core_done && restart && !wr_sc1 && !wr_mode);
      core_abort <= (wr_sc1 || wr_mode) && state_q == ST_CONVERT;
    end
  end

  assign core_cfg = '{channel_select: chan_q, mode_10bit: mode10,
                      long_sample_select: cfg_q[CFG_LONG_SAMPLE_BIT],
                      low_power_config: cfg_q[CFG_LOW_POWER_BIT]};
  assign converter_enable = (state_q != ST_DISABLED);
  assign converter_idle = (state_q == ST_IDLE);

  // ---------------------------------------------------------------
  // Pin control
  // ---------------------------------------------------------------
  logic [15:0] pad_s1, pad_s2;
  always_ff @(posedge clock) begin
    if (reset) begin
      pad_s1 <= 16'h0000;
      pad_s2 <= 16'h0000;
      pad_out <= 16'h0000;
      pad_oe <= 16'h0000;
      pad_pullup <= 16'h0000;
      port_read <= 16'h0000;
    end else begin
      pad_s1 <= pad_in;
      pad_s2 <= pad_s1;
      pad_out <= port_out & ~pin_dis_q;
      pad_oe <= port_oe & ~pin_dis_q;
      pad_pullup <= port_pullup & ~pin_dis_q;
      port_read <= pad_s2 & ~pin_dis_q;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  a_pin_reset_clear: assert property ($past(reset) |-> pin_dis_q == 16'h0000)
    else $error("pin registers not cleared by reset");
  a_pin_tristate: assert property (!(|(pad_oe & $past(pin_dis_q))) && !(|(pad_pullup & $past(pin_dis_q))))
    else $error("disabled pin still driven or pulled up");
  a_pin_read_zero: assert property (!(|(port_read & $past(pin_dis_q))))
    else $error("disabled pin reads non-zero");
  a_off_channel: assert property (chan_q == CHANNEL_OFF |-> state_q == ST_DISABLED && !core_start)
    else $error("converter active with channel all ones");
  a_idle_quiet: assert property ((state_q == ST_IDLE) [*2] |->
    !core_adck_tick && !internal_async_clock_enable)
    else $error("conversion clock running while idle");
  a_round_ten: assert property (xfer && mode10 && !cmp_en_q && !core_result[0] |=>
    res_q == $past(core_result[10:1]))
    else $error("10-bit result misplaced");
  a_round_eight: assert property (xfer && !mode10 && !cmp_en_q && !core_result[0] |=>
    res_q == {2'b00, $past(core_result[8:1])})
    else $error("8-bit result misplaced");
  a_done_irq: assert property (xfer && irq_en_q && !wr_sc1 |=> done_q && done_irq)
    else $error("done flag or interrupt missing");
  a_cmp_fail_keep: assert property (core_done && state_q == ST_CONVERT && !cond |=>
    $stable(res_q) && !$rose(done_q))
    else $error("failed compare stored a result");
  a_div_sixteen: assert property (core_adck_tick && clk_sel == CLK_BUS_HALF &&
    cfg_q[CFG_DIV_LSB +: 2] == 2'b11 && !reg_write |=> !core_adck_tick [*8])
    else $error("conversion clock faster than bus/16");
  a_hw_ignored: assert property (state_q == ST_CONVERT && hw_edge && !core_done && !reg_write |=>
    !core_start)
    else $error("trigger edge restarted a running conversion");
  a_sw_start: assert property (sw_start |=> core_start && state_q == ST_CONVERT)
    else $error("software write did not start conversion");
  a_hw_start: assert property (hw_start |=> core_start ##1 !core_start)
    else $error("trigger edge did not start one conversion");

  c_sw_done: cover property (sw_start ##[1:200] xfer);
  c_hw_cont: cover property (hw_start && cont_q ##[1:200] core_start);
  c_blocked: cover property (core_done && blocked && cond);
  c_cmp_hit: cover property (xfer && cmp_en_q && cmp_gt_q);

endmodule

// >>> hw/adcc_pkg.sv
// Constants, types and register map of the converter control block
package adcc_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_SC1 = 4'h0;
  localparam logic [3:0] ADDR_SC2 = 4'h1;
  localparam logic [3:0] ADDR_CFG = 4'h2;
  localparam logic [3:0] ADDR_RES_HI = 4'h3;
  localparam logic [3:0] ADDR_RES_LO = 4'h4;
  localparam logic [3:0] ADDR_CV_HI = 4'h5;
  localparam logic [3:0] ADDR_CV_LO = 4'h6;
  localparam logic [3:0] ADDR_PIN_MID = 4'h7;
  localparam logic [3:0] ADDR_PIN_HIGH = 4'h8;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int SC1_DONE_BIT = 7;
  localparam int SC1_IRQ_EN_BIT = 6;
  localparam int SC1_CONT_BIT = 5;
  localparam int SC2_ACTIVE_BIT = 7;
  localparam int SC2_HWTRIG_BIT = 6;
  localparam int SC2_CMP_EN_BIT = 5;
  localparam int SC2_CMP_GT_BIT = 4;
  localparam int CFG_LOW_POWER_BIT = 7;
  localparam int CFG_DIV_LSB = 5;
  localparam int CFG_LONG_SAMPLE_BIT = 4;
  localparam int CFG_MODE_LSB = 2;
  localparam int CFG_CLK_LSB = 0;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [4:0] CHANNEL_OFF = 5'h1f;
  localparam logic [7:0] SC2_RESET = 8'h00;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] PIN_RESET = 8'h00;
  localparam logic [9:0] RESULT_RESET = 10'h000;
  localparam logic [9:0] COMPARE_RESET = 10'h000;

  // ---------------------------------------------------------------
  // Enumerations and carriers
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    CLK_BUS = 2'b00,
    CLK_BUS_HALF = 2'b01,
    CLK_ALT = 2'b10,
    CLK_ASYNC = 2'b11
  } adcc_clk_src_t;

  typedef enum logic [1:0] {
    MODE_8BIT = 2'b00,
    MODE_RSVD1 = 2'b01,
    MODE_10BIT = 2'b10,
    MODE_RSVD3 = 2'b11
  } adcc_mode_t;

  typedef enum logic [1:0] {
    ST_DISABLED = 2'b00,
    ST_IDLE = 2'b01,
    ST_CONVERT = 2'b10
  } adcc_state_t;

  typedef struct packed {
    logic [4:0] channel_select;
    logic mode_10bit;
    logic long_sample_select;
    logic low_power_config;
  } adcc_core_cfg_t;

endpackage

// >>> tb/adcc_core_model.sv
// Behavioural model of the analog converter core
`timescale 1ns/1ps
module adcc_core_model import adcc_pkg::*; #(
  parameter int TICKS = 4
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Control from the block
  input wire logic core_start,
  input wire logic core_abort,
  input wire logic core_adck_tick,
  input wire adcc_core_cfg_t core_cfg,
  // Value to convert, set by the bench
  input wire logic [10:0] raw_value,
  // Answer to the block
  output logic core_done,
  output logic [10:0] core_result
);
  logic busy_q;
  logic [10:0] last_q;
  int ticks_q;

  // Finishes after a fixed count of conversion clock ticks
  always_ff @(posedge clock) begin
    core_done <= 1'b0;
    if (reset) begin
      busy_q <= 1'b0;
      ticks_q <= 0;
      last_q <= 11'h000;
    end else if (core_abort) begin
      busy_q <= 1'b0;
      ticks_q <= 0;
    end else if (core_start) begin
      busy_q <= 1'b1;
      ticks_q <= 0;
    end else if (busy_q && core_adck_tick) begin
      ticks_q <= ticks_q + 1;
      if (ticks_q == TICKS - 1) begin
        busy_q <= 1'b0;
        core_done <= 1'b1;
        last_q <= core_cfg.mode_10bit ? raw_value : {2'b00, raw_value[8:0]};
      end
    end
  end

  // No stale copy between answers, so a late sample cannot pass by luck
  assign core_result = core_done ? last_q : ~last_q;
endmodule

// >>> tb/tb_adcc_control.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module tb_adcc_control import adcc_pkg::*; ;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  localparam logic [7:0] SRC_PER [4] = '{8'h01, 8'h02, 8'h06, 8'h0a};
  logic clock, reset, reg_write, reg_read, alt_clk, async_clk, async_en, hw_trig, rd_d;
  logic core_start, core_abort, core_tick, core_done, conv_en, conv_idle, done_irq;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic [10:0] core_result, raw;
  adcc_core_cfg_t core_cfg;
  logic [15:0] port_out, port_oe, port_pullup, pad_in, pad_out, pad_oe, pad_pullup, port_read, m;
  logic [11:0] t;
  logic [9:0] e;
  logic [7:0] exp_q[$];
  logic [31:0] seed;
  int mismatches, n_checks, cycles, n_starts, n_aborts, k;

  adcc_control #(.PIN_COUNT(16)) i_dut (
    .clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .alternate_clock(alt_clk), .internal_async_clock(async_clk),
    .internal_async_clock_enable(async_en), .hw_trigger_input(hw_trig), .core_start(core_start),
    .core_abort(core_abort), .core_adck_tick(core_tick), .core_cfg(core_cfg), .core_done(core_done),
    .core_result(core_result), .converter_enable(conv_en), .converter_idle(conv_idle), .done_irq(done_irq),
    .port_out(port_out), .port_oe(port_oe), .port_pullup(port_pullup), .pad_in(pad_in), .pad_out(pad_out),
    .pad_oe(pad_oe), .pad_pullup(pad_pullup), .port_read(port_read));

  adcc_core_model #(.TICKS(4)) i_core (
    .clock(clock), .reset(reset), .core_start(core_start), .core_abort(core_abort),
    .core_adck_tick(core_tick), .core_cfg(core_cfg), .raw_value(raw), .core_done(core_done),
    .core_result(core_result));

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask

  // Expected read data is queued here and taken off by the monitor
  task automatic rd(input logic [3:0] a, input logic [7:0] x);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    exp_q.push_back(x);
    @(posedge clock);
    reg_read <= 1'b0;
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    @(posedge clock);
    while (conv_idle !== 1'b1 && n < 3000) begin
      @(posedge clock);
      n++;
    end
    chk(16'(conv_idle), 16'h0001);
  endtask

  task automatic tick_gap(input logic [7:0] x);
    logic [7:0] n;
    n = 8'h00;
    while (core_tick !== 1'b1 && n < 8'd200) begin
      @(posedge clock);
      n++;
    end
    n = 8'h00;
    do begin
      @(posedge clock);
      n++;
    end while (core_tick !== 1'b1 && n < 8'd200);
    chk({8'h00, n}, {8'h00, x});
  endtask

  task automatic convert(input logic [7:0] cfg, input logic [10:0] r);
    wr(ADDR_CFG, cfg);
    raw <= r;
    wr(ADDR_SC1, 8'h45);
    wait_idle();
  endtask

  task automatic pulse_trig();
    hw_trig <= 1'b1;
    repeat (2) @(posedge clock);
    hw_trig <= 1'b0;
    repeat (6) @(posedge clock);
  endtask

  // ---------------------------------------------------------------
  // Clock, monitor and sequence
  // ---------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // Source clocks made here, in step with the bus clock, so tick gaps are exact
  always @(posedge clock) begin
    if (rd_d) chk({8'h00, reg_rdata}, {8'h00, exp_q.pop_front()});
    rd_d <= reg_read;
    cycles++;
    if (cycles % 3 == 0) alt_clk <= ~alt_clk;
    if (cycles % 5 == 0) async_clk <= ~async_clk;
    if (core_start === 1'b1) n_starts++;
    if (core_abort === 1'b1) n_aborts++;
    if (cycles > 30000) begin
      mismatches++;
      give_verdict();
    end
  end

  initial begin
    {reset, reg_write, reg_read, hw_trig, alt_clk, async_clk, rd_d} = 7'h40;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    raw = 11'h000;
    seed = $urandom(52688);
    port_out = 16'($urandom);
    port_oe = 16'($urandom);
    port_pullup = 16'($urandom);
    pad_in = 16'($urandom);
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    rd(ADDR_PIN_MID, PIN_RESET);
    rd(ADDR_PIN_HIGH, PIN_RESET);
    rd(ADDR_CFG, CFG_RESET);
    rd(4'hf, 8'h00);
    chk(16'(conv_en), 16'h0000);
    chk(16'(core_cfg), 16'h00f8);
    $display("test reset values done");
    for (int i = 0; i < 3; i++) begin
      m = (i == 0) ? 16'hffff : 16'($urandom);
      pad_in <= 16'($urandom);
      port_oe <= 16'($urandom);
      port_pullup <= 16'($urandom);
      port_out <= 16'($urandom);
      wr(ADDR_PIN_MID, m[7:0]);
      wr(ADDR_PIN_HIGH, m[15:8]);
      rd(ADDR_PIN_MID, m[7:0]);
      rd(ADDR_PIN_HIGH, m[15:8]);
      repeat (4) @(posedge clock);
      chk(pad_oe, port_oe & ~m);
      chk(pad_out, port_out & ~m);
      chk(pad_pullup, port_pullup & ~m);
      chk(port_read, pad_in & ~m);
    end
    $display("test pin control done");
    for (int i = 0; i < 4; i++) begin
      raw = (i == 0) ? 11'h7ff : 11'($urandom);
      t = {1'b0, raw} + 12'h001;
      e = t[11] ? 10'h3ff : t[10:1];
      convert({1'b0, 2'b00, 1'b0, MODE_10BIT, CLK_BUS}, raw);
      chk(16'(done_irq), 16'h0001);
      chk(16'(core_cfg), 16'({5'h05, 1'b1, 2'b00}));
      rd(ADDR_RES_HI, {6'h00, e[9:8]});
      rd(ADDR_RES_LO, e[7:0]);
      t = {3'b000, raw[8:0]} + 12'h001;
      e = t[9] ? 10'h0ff : {2'b00, t[8:1]};
      convert({1'b0, 2'b00, 1'b0, MODE_8BIT, CLK_BUS}, raw);
      rd(ADDR_RES_HI, 8'h00);
      rd(ADDR_RES_LO, e[7:0]);
    end
    $display("test result placement done");
    for (int s = 0; s < 4; s++) begin
      for (int d = 0; d < 4; d++) begin
        wr(ADDR_CFG, {1'b0, 2'(d), 1'b0, MODE_8BIT, 2'(s)});
        wr(ADDR_SC1, 8'h05);
        tick_gap(8'(SRC_PER[s] << d));
        if (s == 3) chk(16'(async_en), 16'h0001);
        wait_idle();
        chk(16'(done_irq), 16'h0000);
      end
    end
    $display("test clock select done");
    wr(ADDR_CFG, {1'b0, 2'b11, 1'b0, MODE_8BIT, CLK_ASYNC});
    wr(ADDR_SC2, 8'h40);
    wr(ADDR_SC1, 8'h05);
    k = n_starts;
    pulse_trig();
    chk(16'(n_starts), 16'(k + 1));
    pulse_trig();
    chk(16'(n_starts), 16'(k + 1));
    wait_idle();
    pulse_trig();
    chk(16'(n_starts), 16'(k + 2));
    wr(ADDR_SC2, SC2_RESET);
    $display("test hardware trigger done");
    wr(ADDR_SC1, 8'h1f);
    k = n_starts;
    repeat (2) @(posedge clock);
    chk(16'(conv_en), 16'h0000);
    chk(16'(n_aborts), 16'h0001);
    chk(16'(n_starts), 16'(k));
    wr(ADDR_CV_HI, 8'h00);
    wr(ADDR_CV_LO, 8'h10);
    wr(ADDR_SC2, 8'h30);
    convert({1'b0, 2'b00, 1'b0, MODE_8BIT, CLK_BUS}, 11'h041);
    rd(ADDR_RES_LO, 8'h11);
    convert({1'b0, 2'b00, 1'b0, MODE_8BIT, CLK_BUS}, 11'h009);
    chk(16'(done_irq), 16'h0000);
    rd(ADDR_RES_LO, 8'h11);
    $display("test compare done");
    repeat (4) @(posedge clock);
    give_verdict();
  end
endmodule
